// *** rtl/hom_pkg.sv ***
package hom_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_METHOD = 8'h04;
  localparam logic [7:0] OFS_SOFT_LIMIT_POSITIVE = 8'h08;
  localparam logic [7:0] OFS_SOFT_LIMIT_NEGATIVE = 8'h0C;
  localparam logic [7:0] OFS_REACTION = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_TARGET = 8'h18;
  // control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_EDIR_BIT = 3;
  localparam int CTRL_ESTOP_BIT = 4;
  // status fields
  localparam int ST_HOMED = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_UNSUP = 2;
  localparam int ST_WARN = 3;
  localparam int ST_FAULT = 4;
  localparam int ST_ENDLESS = 5;
  localparam int ST_DIR = 6;
  // reset values
  localparam logic [31:0] SOFT_LIMIT_RST = 32'h0000_0000;
  localparam logic [5:0] METHOD_RST = 6'h00;
  // method codes
  localparam logic [5:0] M_CAM_FIRST = 6'h0B;
  localparam logic [5:0] M_CAM_LAST = 6'h0E;
  localparam logic [5:0] M_NOIDX_OFS = 6'h10;
  localparam logic [5:0] M_IDX_NEG = 6'h21;
  localparam logic [5:0] M_IDX_POS = 6'h22;
  localparam logic [5:0] M_HERE = 6'h23;
  typedef enum logic [1:0] {MODE_ABS, MODE_REL, MODE_ENDLESS} pos_mode_t;
  typedef enum logic [1:0] {reaction_none, reaction_warning, reaction_fault} reaction_t;
  typedef enum logic [1:0] {EV_RISE, EV_FALL, EV_LEVEL} cam_ev_t;
  typedef enum logic [1:0] {SC_FREE, SC_CAM, SC_LIMIT} scen_t;
  typedef enum logic [1:0] {HS_IDLE, HS_SEEK, HS_ARMED} home_state_t;
endpackage

// *** rtl/homing_and_soft_limit_logic.sv ***
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module homing_and_soft_limit_logic (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic cam_in,
  input wire logic lim_neg_in,
  input wire logic index_in,
  input wire logic [31:0] position_in,
  input wire logic positioning_in,
  output logic home_move_out,
  output logic home_dir_out,
  output logic zero_found_out,
  output logic [31:0] zero_pos_out,
  output logic homed_out,
  output logic move_release_out,
  output logic [31:0] target_out,
  output logic target_reject_out,
  output logic endless_move_out,
  output logic endless_dir_out,
  output logic rapid_stop_out,
  output logic warning_out,
  output logic fault_out
);
  // bus and register file state
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [1:0] mode_r, mode_nxt; // positioning mode of next target
  logic edir_cfg_r, edir_cfg_nxt; // endless direction, 1 = positive
  logic [5:0] method_r, method_nxt;
  logic [31:0] slp_r, slp_nxt; // soft_limit_positive
  logic [31:0] sln_r, sln_nxt; // soft_limit_negative
  logic [1:0] react_r, react_nxt; // soft_limit_fault_reaction
  // homing state
  hom_pkg::home_state_t hs_r, hs_nxt;
  logic hdir_r, hdir_nxt; // 1 = toward positive limit
  logic [1:0] ev_r, ev_nxt; // cam event awaited now
  logic rev_r, rev_nxt; // reverse on that event
  logic [1:0] ev2_r, ev2_nxt; // event awaited after reversal
  logic free_r, free_nxt; // still in free start, limit may reverse
  logic lvl_r, lvl_nxt; // index counts only while cam active
  logic noidx_r, noidx_nxt; // edge alone fixes zero
  logic [1:0] base_r, base_nxt; // method minus first cam method, less 16 for edge-only codes
  logic move_r, move_nxt;
  logic homed_r, homed_nxt;
  logic unsup_r, unsup_nxt;
  logic zero_r, zero_nxt;
  logic [31:0] zpos_r, zpos_nxt;
  logic cam_q_r; // cam one cycle ago, for edges
  // soft limit state
  logic [31:0] tgt_r, tgt_nxt;
  logic rel_r, rel_nxt;
  logic rej_r, rej_nxt;
  logic endl_r, endl_nxt;
  logic edir_r, edir_nxt;
  logic rstop_r, rstop_nxt;
  logic warn_r, warn_nxt;
  logic fault_r, fault_nxt;
  // decoded strobes
  logic acc, wr_en, start, wr_tgt, sl_en, sl_evt, found, hit;
  logic cam_rise, cam_fall;
  logic [31:0] tgt_calc;
  logic [4:0] plan;
  logic [5:0] mofs;

  // search plan: {first event, reverse on it, event after reversal}
  function automatic logic [4:0] plan_f(input logic [1:0] b, input hom_pkg::scen_t sc);
    logic [4:0] p;
    p = {hom_pkg::EV_FALL, 1'b0, hom_pkg::EV_FALL}; // pass cam, take index
    case (sc)
      hom_pkg::SC_FREE: begin
        case (b)
          2'd0: p = {hom_pkg::EV_RISE, 1'b1, hom_pkg::EV_FALL};
          2'd1: p = {hom_pkg::EV_LEVEL, 1'b0, hom_pkg::EV_LEVEL};
          2'd2: p = {hom_pkg::EV_FALL, 1'b1, hom_pkg::EV_RISE};
          default: p = {hom_pkg::EV_FALL, 1'b0, hom_pkg::EV_FALL};
        endcase
      end
      hom_pkg::SC_CAM: begin
        // 11 and 14 take index after fall, 12 and 13 reverse
        if (b == 2'd1 || b == 2'd2) begin
          p = {hom_pkg::EV_FALL, 1'b1, hom_pkg::EV_RISE};
        end
      end
      default: begin
        case (b)
          2'd0: p = {hom_pkg::EV_FALL, 1'b0, hom_pkg::EV_FALL};
          2'd1: p = {hom_pkg::EV_FALL, 1'b1, hom_pkg::EV_RISE};
          2'd2: p = {hom_pkg::EV_LEVEL, 1'b0, hom_pkg::EV_LEVEL};
          default: p = {hom_pkg::EV_RISE, 1'b1, hom_pkg::EV_FALL};
        endcase
      end
    endcase
    return p;
  endfunction

  // signed window test, limits inclusive
  function automatic logic in_range_f(input logic [31:0] t, input logic [31:0] lo,
                                      input logic [31:0] hi);
    return ($signed(t) >= $signed(lo)) && ($signed(t) <= $signed(hi));
  endfunction

  // strobes: a write lands only on the completing access edge
  assign acc = psel_in & penable_in;
  assign wr_en = acc & pready_r & pwrite_in;
  assign start = wr_en && paddr_in == hom_pkg::OFS_CTRL && pwdata_in[hom_pkg::CTRL_START_BIT];
  assign wr_tgt = wr_en && paddr_in == hom_pkg::OFS_TARGET;
  assign cam_rise = cam_in & ~cam_q_r;
  assign cam_fall = ~cam_in & cam_q_r;
  // limits live only when positioning, homed, and not both zero
  assign sl_en = homed_r & positioning_in &
                 ~(slp_r == 32'h0000_0000 && sln_r == 32'h0000_0000);
  assign tgt_calc = (mode_r == hom_pkg::MODE_REL) ? position_in + pwdata_in : pwdata_in;
  assign mofs = method_r - hom_pkg::M_NOIDX_OFS;

  // bus slave: one wait state so read data comes from a flop
  always_comb begin
    pready_nxt = acc & ~pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    mode_nxt = mode_r;
    edir_cfg_nxt = edir_cfg_r;
    method_nxt = method_r;
    slp_nxt = slp_r;
    sln_nxt = sln_r;
    react_nxt = react_r;
    if (acc & ~pready_r) begin
      prdata_nxt = 32'h0000_0000;
      if (paddr_in == hom_pkg::OFS_CTRL) begin
        prdata_nxt[hom_pkg::CTRL_MODE_LSB +: 2] = mode_r;
        prdata_nxt[hom_pkg::CTRL_EDIR_BIT] = edir_cfg_r;
      end else if (paddr_in == hom_pkg::OFS_METHOD) begin
        prdata_nxt[5:0] = method_r;
      end else if (paddr_in == hom_pkg::OFS_SOFT_LIMIT_POSITIVE) begin
        prdata_nxt = slp_r;
      end else if (paddr_in == hom_pkg::OFS_SOFT_LIMIT_NEGATIVE) begin
        prdata_nxt = sln_r;
      end else if (paddr_in == hom_pkg::OFS_REACTION) begin
        prdata_nxt[1:0] = react_r;
      end else if (paddr_in == hom_pkg::OFS_STATUS) begin
        prdata_nxt[hom_pkg::ST_HOMED] = homed_r;
        prdata_nxt[hom_pkg::ST_BUSY] = move_r;
        prdata_nxt[hom_pkg::ST_UNSUP] = unsup_r;
        prdata_nxt[hom_pkg::ST_WARN] = warn_r;
        prdata_nxt[hom_pkg::ST_FAULT] = fault_r;
        prdata_nxt[hom_pkg::ST_ENDLESS] = endl_r;
        prdata_nxt[hom_pkg::ST_DIR] = hdir_r;
      end else if (paddr_in == hom_pkg::OFS_TARGET) begin
        prdata_nxt = tgt_r;
      end else begin
        pslverr_nxt = 1'b1; // unmapped address
      end
    end
    // writes; status and target side effects live in the limit group
    if (wr_en) begin
      if (paddr_in == hom_pkg::OFS_CTRL) begin
        mode_nxt = pwdata_in[hom_pkg::CTRL_MODE_LSB +: 2];
        edir_cfg_nxt = pwdata_in[hom_pkg::CTRL_EDIR_BIT];
      end else if (paddr_in == hom_pkg::OFS_METHOD) begin
        method_nxt = pwdata_in[5:0];
      end else if (paddr_in == hom_pkg::OFS_SOFT_LIMIT_POSITIVE) begin
        slp_nxt = pwdata_in;
      end else if (paddr_in == hom_pkg::OFS_SOFT_LIMIT_NEGATIVE) begin
        sln_nxt = pwdata_in;
      end else if (paddr_in == hom_pkg::OFS_REACTION) begin
        react_nxt = pwdata_in[1:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      mode_r <= hom_pkg::MODE_ABS;
      edir_cfg_r <= 1'b0;
      method_r <= hom_pkg::METHOD_RST;
      slp_r <= hom_pkg::SOFT_LIMIT_RST;
      sln_r <= hom_pkg::SOFT_LIMIT_RST;
      react_r <= hom_pkg::reaction_none;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      mode_r <= mode_nxt;
      edir_cfg_r <= edir_cfg_nxt;
      method_r <= method_nxt;
      slp_r <= slp_nxt;
      sln_r <= sln_nxt;
      react_r <= react_nxt;
    end
  end

  // homing search: seek cam events, then qualify the zero point
  always_comb begin
    hs_nxt = hs_r;
    hdir_nxt = hdir_r;
    ev_nxt = ev_r;
    rev_nxt = rev_r;
    ev2_nxt = ev2_r;
    free_nxt = free_r;
    lvl_nxt = lvl_r;
    noidx_nxt = noidx_r;
    base_nxt = base_r;
    homed_nxt = homed_r;
    unsup_nxt = unsup_r;
    zpos_nxt = zpos_r;
    found = 1'b0;
    plan = 5'h00;
    case (ev_r)
      hom_pkg::EV_RISE: hit = cam_rise;
      hom_pkg::EV_FALL: hit = cam_fall;
      default: hit = cam_in;
    endcase
    if (start) begin
      // a new search drops the old zero point
      homed_nxt = 1'b0;
      unsup_nxt = 1'b0;
      lvl_nxt = 1'b0;
      free_nxt = 1'b0;
      noidx_nxt = 1'b0;
      hs_nxt = hom_pkg::HS_IDLE;
      if ((method_r >= hom_pkg::M_CAM_FIRST && method_r <= hom_pkg::M_CAM_LAST) ||
          (mofs >= hom_pkg::M_CAM_FIRST && mofs <= hom_pkg::M_CAM_LAST)) begin
        noidx_nxt = method_r > hom_pkg::M_CAM_LAST;
        base_nxt = noidx_nxt ? 2'(mofs - hom_pkg::M_CAM_FIRST) :
                               2'(method_r - hom_pkg::M_CAM_FIRST);
        if (cam_in) begin
          // 11 and 12 leave the cam toward positive, 13 and 14 negative
          hdir_nxt = ~base_nxt[1];
          plan = plan_f(base_nxt, hom_pkg::SC_CAM);
        end else if (lim_neg_in) begin
          hdir_nxt = 1'b1; // already on the limit: as if reversed there
          plan = plan_f(base_nxt, hom_pkg::SC_LIMIT);
        end else begin
          hdir_nxt = 1'b0;
          free_nxt = 1'b1;
          plan = plan_f(base_nxt, hom_pkg::SC_FREE);
        end
        {ev_nxt, rev_nxt, ev2_nxt} = plan;
        hs_nxt = hom_pkg::HS_SEEK;
      end else if (method_r == hom_pkg::M_IDX_NEG || method_r == hom_pkg::M_IDX_POS) begin
        hdir_nxt = method_r == hom_pkg::M_IDX_POS;
        hs_nxt = hom_pkg::HS_ARMED;
      end else if (method_r == hom_pkg::M_HERE) begin
        found = 1'b1; // no motion, position kept as is
      end else begin
        unsup_nxt = 1'b1; // 15, 16, 31, 32 and undefined codes
      end
    end else begin
      case (hs_r)
        hom_pkg::HS_SEEK: begin
          if (free_r && lim_neg_in && !hdir_r) begin
            hdir_nxt = 1'b1;
            free_nxt = 1'b0;
            plan = plan_f(base_r, hom_pkg::SC_LIMIT);
            {ev_nxt, rev_nxt, ev2_nxt} = plan;
          end else if (hit) begin
            if (rev_r) begin
              hdir_nxt = ~hdir_r;
              ev_nxt = ev2_r;
              rev_nxt = 1'b0;
            end else if (noidx_r) begin
              found = 1'b1;
            end else begin
              hs_nxt = hom_pkg::HS_ARMED;
              lvl_nxt = ev_r == hom_pkg::EV_LEVEL;
            end
          end
        end
        hom_pkg::HS_ARMED: begin
          // level plans need the cam active under the index
          if (index_in && (cam_in || !lvl_r)) begin
            found = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (found) begin
      hs_nxt = hom_pkg::HS_IDLE;
      homed_nxt = 1'b1;
      zpos_nxt = position_in;
    end
    zero_nxt = found;
    move_nxt = hs_nxt != hom_pkg::HS_IDLE;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hs_r <= hom_pkg::HS_IDLE;
      hdir_r <= 1'b0;
      ev_r <= hom_pkg::EV_RISE;
      rev_r <= 1'b0;
      ev2_r <= hom_pkg::EV_RISE;
      free_r <= 1'b0;
      lvl_r <= 1'b0;
      noidx_r <= 1'b0;
      base_r <= 2'd0;
      move_r <= 1'b0;
      homed_r <= 1'b0;
      unsup_r <= 1'b0;
      zero_r <= 1'b0;
      zpos_r <= 32'h0000_0000;
      cam_q_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      hdir_r <= hdir_nxt;
      ev_r <= ev_nxt;
      rev_r <= rev_nxt;
      ev2_r <= ev2_nxt;
      free_r <= free_nxt;
      lvl_r <= lvl_nxt;
      noidx_r <= noidx_nxt;
      base_r <= base_nxt;
      move_r <= move_nxt;
      homed_r <= homed_nxt;
      unsup_r <= unsup_nxt;
      zero_r <= zero_nxt;
      zpos_r <= zpos_nxt;
      cam_q_r <= cam_in;
    end
  end

  // soft limits: target check, endless watch, sticky reaction flags
  always_comb begin
    tgt_nxt = tgt_r;
    rel_nxt = 1'b0;
    rej_nxt = 1'b0;
    endl_nxt = endl_r;
    edir_nxt = edir_r;
    rstop_nxt = 1'b0;
    sl_evt = 1'b0;
    warn_nxt = warn_r;
    fault_nxt = fault_r;
    if (wr_en && paddr_in == hom_pkg::OFS_STATUS) begin
      // write one to clear; a same-cycle event below wins
      warn_nxt = warn_r & ~pwdata_in[hom_pkg::ST_WARN];
      fault_nxt = fault_r & ~pwdata_in[hom_pkg::ST_FAULT];
    end
    if (wr_en && paddr_in == hom_pkg::OFS_CTRL && pwdata_in[hom_pkg::CTRL_ESTOP_BIT]) begin
      endl_nxt = 1'b0;
    end
    if (wr_tgt) begin
      if (mode_r == hom_pkg::MODE_ENDLESS) begin
        endl_nxt = 1'b1;
        edir_nxt = edir_cfg_r;
      end else if (sl_en && !in_range_f(tgt_calc, sln_r, slp_r)) begin
        rej_nxt = 1'b1; // no motion for this target
        sl_evt = 1'b1;
      end else begin
        rel_nxt = 1'b1;
        tgt_nxt = tgt_calc;
      end
    end
    if (endl_r && sl_en &&
        ((edir_r && $signed(position_in) >= $signed(slp_r)) ||
         (!edir_r && $signed(position_in) <= $signed(sln_r)))) begin
      endl_nxt = 1'b0;
      rstop_nxt = 1'b1; // whatever the reaction setting
      sl_evt = 1'b1;
    end
    if (sl_evt) begin
      // configured reaction; none still blocks or stops the motion
      if (react_r == hom_pkg::reaction_warning) begin
        warn_nxt = 1'b1;
      end else if (react_r == hom_pkg::reaction_fault) begin
        fault_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tgt_r <= 32'h0000_0000;
      rel_r <= 1'b0;
      rej_r <= 1'b0;
      endl_r <= 1'b0;
      edir_r <= 1'b0;
      rstop_r <= 1'b0;
      warn_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      tgt_r <= tgt_nxt;
      rel_r <= rel_nxt;
      rej_r <= rej_nxt;
      endl_r <= endl_nxt;
      edir_r <= edir_nxt;
      rstop_r <= rstop_nxt;
      warn_r <= warn_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign home_move_out = move_r;
  assign home_dir_out = hdir_r;
  assign zero_found_out = zero_r;
  assign zero_pos_out = zpos_r;
  assign homed_out = homed_r;
  assign move_release_out = rel_r;
  assign target_out = tgt_r;
  assign target_reject_out = rej_r;
  assign endless_move_out = endl_r;
  assign endless_dir_out = edir_r;
  assign rapid_stop_out = rstop_r;
  assign warning_out = warn_r;
  assign fault_out = fault_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic unsup_out_chk; // unsupported status with no motion and no zero point
  property p_unsup;
    start && (method_r == 6'h0F || method_r == 6'h10 || method_r == 6'h1F ||
              method_r == 6'h20) |=> unsup_out_chk;
  endproperty
  assign unsup_out_chk = unsup_r && !home_move_out && !homed_out;
  a_unsup: assert property (p_unsup) else $error("unsupported method moved");
  property p_here;
    start && method_r == hom_pkg::M_HERE |=> zero_found_out && homed_out &&
      !home_move_out && zero_pos_out == $past(position_in);
  endproperty
  a_here: assert property (p_here) else $error("method 35 wrong");
  property p_limrev;
    !start && hs_r == hom_pkg::HS_SEEK && free_r && lim_neg_in && !hdir_r
      |=> home_dir_out && home_move_out;
  endproperty
  a_limrev: assert property (p_limrev) else $error("no reversal at limit");
  property p_level;
    !start && hs_r == hom_pkg::HS_ARMED && lvl_r && index_in && !cam_in |=> !zero_found_out;
  endproperty
  a_level: assert property (p_level) else $error("index taken off cam");
  property p_idx;
    !start && hs_r == hom_pkg::HS_ARMED && !lvl_r && index_in |=> zero_found_out ##1 !zero_found_out;
  endproperty
  a_idx: assert property (p_idx) else $error("index not taken");
  property p_gate;
    wr_tgt && !positioning_in |=> !target_reject_out;
  endproperty
  a_gate: assert property (p_gate) else $error("limit active outside positioning");
  property p_off;
    wr_tgt && slp_r == 32'h0000_0000 && sln_r == 32'h0000_0000 &&
      mode_r != hom_pkg::MODE_ENDLESS |=> move_release_out;
  endproperty
  a_off: assert property (p_off) else $error("zero limits not disabled");
  property p_reject;
    wr_tgt && sl_en && mode_r != hom_pkg::MODE_ENDLESS && !in_range_f(tgt_calc, sln_r, slp_r)
      |=> target_reject_out && !move_release_out;
  endproperty
  a_reject: assert property (p_reject) else $error("bad target released");
  property p_endless;
    endl_r && sl_en && edir_r && $signed(position_in) >= $signed(slp_r)
      |=> rapid_stop_out && !endless_move_out;
  endproperty
  a_endless: assert property (p_endless) else $error("no stop at soft limit");
  property p_homed;
    zero_found_out |-> homed_out && !home_move_out;
  endproperty
  a_homed: assert property (p_homed) else $error("zero without homed");
  c_home: cover property (start ##[1:200] zero_found_out);
  c_rev: cover property (hs_r == hom_pkg::HS_SEEK && free_r && lim_neg_in && !hdir_r);
  c_rej: cover property (target_reject_out);
  c_stop: cover property (rapid_stop_out);
endmodule
`default_nettype wire

// *** testbench/axis_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// axis stand-in: one count per clock while any travel is requested
module axis_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic move_in,
  input wire logic dir_in,
  output logic cam_out,
  output logic lim_neg_out,
  output logic index_out,
  output logic [31:0] position_out
);
  // live position, up when moving positive
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      position_out <= 32'h0000_0000;
    end else if (move_in) begin
      position_out <= dir_in ? position_out + 32'h1 : position_out - 32'h1;
    end
  end
  // cam spans -40..-30, so the index at -16 must not qualify
  assign cam_out = ($signed(position_out) <= 32'shFFFF_FFE2) &&
                   ($signed(position_out) >= 32'shFFFF_FFD8);
  // index every 16 counts
  assign index_out = (position_out[3:0] == 4'h0);
  // limit far past the cam, hit only in the method 13 search, which reverses there
  assign lim_neg_out = ($signed(position_out) <= 32'shFFFF_FF38);
endmodule
`default_nettype wire

// *** testbench/homing_and_soft_limit_logic_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module homing_and_soft_limit_logic_test;
  logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in, positioning_in;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, zero_pos_out, target_out, position_in, rd;
  logic pready_out, pslverr_out, cam_in, lim_neg_in, index_in, er;
  logic home_move_out, home_dir_out, zero_found_out, homed_out, move_release_out;
  logic target_reject_out, endless_move_out, endless_dir_out, rapid_stop_out;
  logic warning_out, fault_out;
  int n_errors = 0;
  int checks_done = 0;
  int n;
  // unsupported codes and the no-motion method, with expected status bits 2:0
  logic [5:0] row_m [6] = '{6'h0F, 6'h10, 6'h1F, 6'h20, 6'h11, 6'h23};
  logic [31:0] row_s [6] = '{32'h4, 32'h4, 32'h4, 32'h4, 32'h4, 32'h1};
  homing_and_soft_limit_logic dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .cam_in(cam_in), .lim_neg_in(lim_neg_in),
    .index_in(index_in), .position_in(position_in), .positioning_in(positioning_in),
    .home_move_out(home_move_out), .home_dir_out(home_dir_out),
    .zero_found_out(zero_found_out), .zero_pos_out(zero_pos_out), .homed_out(homed_out),
    .move_release_out(move_release_out), .target_out(target_out),
    .target_reject_out(target_reject_out), .endless_move_out(endless_move_out),
    .endless_dir_out(endless_dir_out), .rapid_stop_out(rapid_stop_out),
    .warning_out(warning_out), .fault_out(fault_out));
  // the axis follows whichever travel the block requests
  axis_model axis (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .move_in(home_move_out | endless_move_out),
    .dir_in(home_move_out ? home_dir_out : endless_dir_out), .cam_out(cam_in),
    .lim_neg_out(lim_neg_in), .index_out(index_in), .position_out(position_in));
  // 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // word and flag comparisons
  task automatic chk32(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk1(input string nm, input logic ex, input logic got);
    chk32(nm, {31'h0, ex}, {31'h0, got});
  endtask
  // target write, then look at the pulse one cycle later
  task automatic target(input logic [31:0] t);
    apb(1'b1, hom_pkg::OFS_TARGET, t);
    @(posedge clk_in);
  endtask
  task automatic limits(input logic [31:0] p, input logic [31:0] q);
    apb(1'b1, hom_pkg::OFS_SOFT_LIMIT_POSITIVE, p);
    apb(1'b1, hom_pkg::OFS_SOFT_LIMIT_NEGATIVE, q);
  endtask
  // one homing run: wait for the zero pulse, then check where it was taken
  task automatic home(input logic [5:0] m, input logic [31:0] z);
    int w;
    apb(1'b1, hom_pkg::OFS_METHOD, {26'h0, m});
    apb(1'b1, hom_pkg::OFS_CTRL, 32'h0000_0001);
    w = 0;
    while (zero_found_out !== 1'b1 && w < 400) begin
      @(posedge clk_in);
      w++;
    end
    chk1("zero_found", 1'b1, zero_found_out);
    chk32("zero_pos", z, zero_pos_out);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog: the whole run needs well under 4000 cycles
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
  initial begin
    rst_n_in = 1'b0;
    {psel_in, penable_in, pwrite_in, positioning_in} = 4'h0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0000_0000;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // table of method codes that never move the axis
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, hom_pkg::OFS_METHOD, {26'h0, row_m[i]});
      apb(1'b1, hom_pkg::OFS_CTRL, 32'h0000_0001);
      apb(1'b0, hom_pkg::OFS_STATUS, 32'h0);
      chk32("status", row_s[i], rd & 32'h0000_0007);
      chk1("home_move", 1'b0, home_move_out);
    end
    $display("test methods done");
    // second reset in mid-run, then reset values and an unmapped place
    apb(1'b1, hom_pkg::OFS_SOFT_LIMIT_POSITIVE, 32'h0000_0055);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk1("homed", 1'b0, homed_out);
    apb(1'b0, hom_pkg::OFS_SOFT_LIMIT_POSITIVE, 32'h0);
    chk32("limit_pos", 32'h0000_0000, rd);
    apb(1'b0, hom_pkg::OFS_SOFT_LIMIT_NEGATIVE, 32'h0);
    chk32("limit_neg", 32'h0000_0000, rd);
    apb(1'b1, 8'h40, 32'h0000_0005);
    chk1("slverr", 1'b1, er);
    $display("test reset done");
    // limits ignored before homing
    positioning_in <= 1'b1;
    limits(32'h0000_0064, 32'hFFFF_FF9C);
    target(32'h0000_00C8);
    chk1("release", 1'b1, move_release_out);
    // searches: free start, cam start, limit reversal, edge-only zero
    home(6'h0C, 32'hFFFF_FFE0);
    @(posedge clk_in);
    chk1("homed", 1'b1, homed_out);
    home(6'h0E, 32'hFFFF_FFD0);
    home(6'h0D, 32'hFFFF_FFE0);
    chk1("home_dir", 1'b1, home_dir_out);
    home(6'h1C, 32'hFFFF_FFE2);
    $display("test homing done");
    // limits now checked
    target(32'h0000_00C8);
    chk1("reject", 1'b1, target_reject_out);
    target(32'h0000_0032);
    chk1("release", 1'b1, move_release_out);
    chk32("target", 32'h0000_0032, target_out);
    positioning_in <= 1'b0;
    target(32'h0000_00C8);
    chk1("release", 1'b1, move_release_out);
    positioning_in <= 1'b1;
    limits(32'h0000_0000, 32'h0000_0000);
    target(32'h0000_00C8);
    chk1("release", 1'b1, move_release_out);
    $display("test targets done");
    // endless positive run into the positive limit with reaction none
    limits(32'h0000_0064, 32'hFFFF_FF9C);
    apb(1'b1, hom_pkg::OFS_CTRL, 32'h0000_000C);
    target(32'h0000_0000);
    n = 0;
    while (rapid_stop_out !== 1'b1 && n < 400) begin
      @(posedge clk_in);
      n++;
    end
    chk1("rapid_stop", 1'b1, rapid_stop_out);
    chk1("stop_pos", 1'b1, $signed(position_in) >= 100 && $signed(position_in) <= 103);
    chk1("warning", 1'b0, warning_out);
    @(posedge clk_in);
    chk1("endless", 1'b0, endless_move_out);
    $display("test endless done");
    // relative target, then a rejected one with the fault reaction and its clear
    apb(1'b1, hom_pkg::OFS_CTRL, 32'h0000_0002);
    target(32'hFFFF_FF6A);
    chk1("release", 1'b1, move_release_out);
    chk32("target", position_in + 32'hFFFF_FF6A, target_out);
    apb(1'b1, hom_pkg::OFS_REACTION, 32'h0000_0002);
    target(32'h0000_000A);
    chk1("reject", 1'b1, target_reject_out);
    chk1("fault", 1'b1, fault_out);
    apb(1'b1, hom_pkg::OFS_STATUS, 32'h0000_0010);
    @(posedge clk_in);
    chk1("fault", 1'b0, fault_out);
    chk1("endless_dir", 1'b1, endless_dir_out);
    $display("test faults done");
    finish_test();
  end
endmodule
`default_nettype wire
